// ==== rtl/bcr_exec.sv ====
// Branch-condition evaluation, subroutine call/return and bit read-modify-write execution.
//
// Operation
// RQ1: A branch is taken only when the condition field's test of C, Z, N and V holds.
// RQ2: A bit-clear on a memory byte starts with a byte read of the addressed location.
// RQ3: A byte read of a write-only location yields all ones instead of its contents.
// RQ4: After the read only the selected bit is changed, every other bit stays as read.
// RQ5: The whole modified byte is written back to the same address.
// RQ6: A relative call jumps to the current address plus the displacement and saves the return.
// RQ7: A return resumes at the point saved by the most recent call.
// RQ8: Set, clear, invert, carry-store and inverted carry-store all run as read, modify, write.
// RQ9: The target bit is chosen by a 3-bit bit number covering positions 0 to 7.
// RQ10: Register-direct bit instructions take bit number from bits 6:4, register from 3:0.
`timescale 1ns/1ps
`default_nettype none
`include "bcr_consts.svh"

module bcr_exec
  import bcr_pkg::*;
(
  input wire logic core_clk_in, // System clock
  input wire logic reset_in, // Asynchronous reset, active high
  input wire logic instr_valid_in, // Start one instruction
  input wire bcr_kind_e instr_kind_in, // Instruction class
  input wire logic [3:0] condition_field_in, // Branch condition field
  input wire bcr_bitop_e bit_op_in, // Bit modify operation
  input wire logic [7:0] op_byte_in, // Second opcode byte
  input wire logic [15:0] addr_in, // Memory operand address
  input wire logic [7:0] disp_in, // Signed branch or call displacement
  input wire logic [15:0] cur_pc_in, // Current address, past the instruction
  input wire logic flag_c_in, // Carry flag
  input wire logic flag_z_in, // Zero flag
  input wire logic flag_n_in, // Negative flag
  input wire logic flag_v_in, // Overflow flag
  input wire logic mem_ack_in, // Bus cycle complete
  input wire logic [7:0] mem_rdata_in, // Bus read data
  input wire logic mem_wo_in, // Addressed location is write-only
  input wire logic reg_load_in, // Load a general register byte
  input wire logic [3:0] reg_load_idx_in, // Register to load
  input wire logic [7:0] reg_load_data_in, // Data to load
  input wire logic [3:0] reg_rd_idx_in, // Register to observe
  output logic busy_out, // Instruction in progress
  output logic done_out, // One-cycle pulse at completion
  output logic pc_valid_out, // Pulse with a new program counter
  output logic [15:0] pc_out, // Next program counter
  output logic branch_taken_out, // Last branch condition result
  output logic mem_req_out, // Bus request, held until ack
  output logic mem_we_out, // Bus write when high, read when low
  output logic [15:0] mem_addr_out, // Bus address
  output logic [7:0] mem_wdata_out, // Bus write data
  output logic [7:0] reg_rd_data_out // Observed register byte
);

  // ***************************************************************
  // Condition evaluation
  // ***************************************************************
  function automatic logic cond_true(input logic [3:0] cc, input logic c, input logic z,
                                     input logic n, input logic v);
    logic r;
    r = 1'b0;
    case (cc)
      `BCR_CC_ALWAYS: r = 1'b1;
      `BCR_CC_NEVER: r = 1'b0;
      `BCR_CC_HI: r = ~(c | z);
      `BCR_CC_LS: r = c | z;
      `BCR_CC_CARRY_CLR: r = ~c;
      `BCR_CC_CARRY_SET: r = c;
      `BCR_CC_NOT_EQ: r = ~z;
      `BCR_CC_EQ: r = z;
      `BCR_CC_OVF_CLR: r = ~v;
      `BCR_CC_OVF_SET: r = v;
      `BCR_CC_PLUS: r = ~n;
      `BCR_CC_MINUS: r = n;
      `BCR_CC_GE: r = ~(n ^ v);
      `BCR_CC_LT: r = n ^ v;
      `BCR_CC_GT: r = ~(z | (n ^ v));
      `BCR_CC_LE: r = z | (n ^ v);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ***************************************************************
  // State and storage
  // ***************************************************************
  typedef enum logic [1:0] {
    BCR_S_IDLE,
    BCR_S_READ,
    BCR_S_WRITE
  } bcr_state_e;

  bcr_state_e state_reg;
  bcr_bitop_e op_reg;
  logic [2:0] bit_no_reg;
  logic carry_reg;
  logic [7:0] rf_mem [`BCR_NREGS];
  logic [15:0] stack_mem [`BCR_STACK_DEPTH];
  logic [2:0] sp_reg;

  logic start;
  logic [15:0] disp_ext;
  logic [3:0] reg_no;
  logic [2:0] imm_bit_no;
  logic [7:0] read_byte;
  logic [7:0] mod_in;
  logic [7:0] mod_out;
  bcr_bitop_e mod_op;
  logic [2:0] mod_bit;
  logic mod_carry;

  // New instructions are only taken while idle.
  assign start = instr_valid_in & (state_reg == BCR_S_IDLE);
  assign disp_ext = {{8{disp_in[7]}}, disp_in};
  assign reg_no = op_byte_in[`BCR_REGNO_MSB:`BCR_REGNO_LSB]; // RQ10
  assign imm_bit_no = op_byte_in[`BCR_BITNO_MSB:`BCR_BITNO_LSB]; // RQ9 RQ10
  // Write-only locations cannot be read back, so the bus data is replaced.
  assign read_byte = mem_wo_in ? `BCR_WO_READ : mem_rdata_in; // RQ3

  // In idle the modifier serves a register-direct op; otherwise the memory op in flight.
  always_comb begin
    if (state_reg == BCR_S_IDLE) begin
      mod_in = rf_mem[reg_no];
      mod_op = bit_op_in;
      mod_bit = imm_bit_no;
      mod_carry = flag_c_in;
    end else begin
      mod_in = read_byte;
      mod_op = op_reg;
      mod_bit = bit_no_reg;
      mod_carry = carry_reg;
    end
  end

  bcr_bit_modify u_modify (
    .byte_in(mod_in),
    .bit_no_in(mod_bit),
    .op_in(mod_op),
    .carry_in(mod_carry),
    .byte_out(mod_out)
  );

  // ***************************************************************
  // Memory read-modify-write sequence
  // ***************************************************************
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= BCR_S_IDLE;
      op_reg <= BCR_BIT_SET;
      bit_no_reg <= 3'h0;
      carry_reg <= 1'b0;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_addr_out <= `BCR_PC_RESET;
      mem_wdata_out <= `BCR_BYTE_RESET;
    end else begin
      case (state_reg)
        BCR_S_IDLE: begin
          if (start && instr_kind_in == BCR_K_BIT_MEM) begin
            state_reg <= BCR_S_READ; // RQ8
            op_reg <= bit_op_in;
            bit_no_reg <= op_byte_in[`BCR_BITNO_MSB:`BCR_BITNO_LSB]; // RQ9
            carry_reg <= flag_c_in;
            mem_req_out <= 1'b1; // RQ2
            mem_we_out <= 1'b0; // RQ2
            mem_addr_out <= addr_in;
          end
        end
        BCR_S_READ: begin
          if (mem_ack_in) begin
            state_reg <= BCR_S_WRITE;
            mem_we_out <= 1'b1; // RQ5
            mem_wdata_out <= mod_out; // RQ4 RQ5
          end
        end
        BCR_S_WRITE: begin
          if (mem_ack_in) begin
            state_reg <= BCR_S_IDLE;
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
          end
        end
        default: begin
          state_reg <= BCR_S_IDLE;
          mem_req_out <= 1'b0;
          mem_we_out <= 1'b0;
        end
      endcase
    end
  end

  // ***************************************************************
  // General registers
  // ***************************************************************
  // A register-direct bit op has priority over a load to the same cycle.
  always_ff @(posedge core_clk_in) begin
    if (start && instr_kind_in == BCR_K_BIT_REG) begin
      rf_mem[reg_no] <= mod_out; // RQ8 RQ10
    end else if (reg_load_in) begin
      rf_mem[reg_load_idx_in] <= reg_load_data_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rd_data_out <= `BCR_BYTE_RESET;
    end else begin
      reg_rd_data_out <= rf_mem[reg_rd_idx_in];
    end
  end

  // ***************************************************************
  // Return-address stack
  // ***************************************************************
  // The stack wraps at its depth; calls nested deeper lose the oldest entry.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sp_reg <= 3'h0;
    end else if (start && instr_kind_in == BCR_K_CALL) begin
      sp_reg <= sp_reg + 3'h1;
    end else if (start && instr_kind_in == BCR_K_RETURN) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (start && instr_kind_in == BCR_K_CALL) begin
      stack_mem[sp_reg] <= cur_pc_in; // RQ6
    end
  end

  // ***************************************************************
  // Program flow and completion
  // ***************************************************************
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pc_out <= `BCR_PC_RESET;
      pc_valid_out <= 1'b0;
      branch_taken_out <= 1'b0;
    end else begin
      pc_valid_out <= 1'b0;
      if (start) begin
        case (instr_kind_in)
          BCR_K_BRANCH: begin
            pc_valid_out <= 1'b1;
            if (cond_true(condition_field_in, flag_c_in, flag_z_in, flag_n_in, flag_v_in)) begin
              branch_taken_out <= 1'b1; // RQ1
              pc_out <= cur_pc_in + disp_ext; // RQ1
            end else begin
              branch_taken_out <= 1'b0; // RQ1
              pc_out <= cur_pc_in;
            end
          end
          BCR_K_CALL: begin
            pc_valid_out <= 1'b1;
            pc_out <= cur_pc_in + disp_ext; // RQ6
          end
          BCR_K_RETURN: begin
            pc_valid_out <= 1'b1;
            pc_out <= stack_mem[sp_reg - 3'h1]; // RQ7
          end
          default: pc_valid_out <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      done_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      done_out <= (start && instr_kind_in != BCR_K_BIT_MEM) ||
                  (state_reg == BCR_S_WRITE && mem_ack_in);
      busy_out <= (start && instr_kind_in == BCR_K_BIT_MEM) ||
                  (state_reg == BCR_S_READ) ||
                  (state_reg == BCR_S_WRITE && !mem_ack_in);
    end
  end

endmodule

`default_nettype wire

// ==== shared/bcr_consts.svh ====
// Constants of the branch-condition and bit read-modify-write block.
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH

// Condition field encodings.
`define BCR_CC_ALWAYS 4'h0
`define BCR_CC_NEVER 4'h1
`define BCR_CC_HI 4'h2
`define BCR_CC_LS 4'h3
`define BCR_CC_CARRY_CLR 4'h4
`define BCR_CC_CARRY_SET 4'h5
`define BCR_CC_NOT_EQ 4'h6
`define BCR_CC_EQ 4'h7
`define BCR_CC_OVF_CLR 4'h8
`define BCR_CC_OVF_SET 4'h9
`define BCR_CC_PLUS 4'ha
`define BCR_CC_MINUS 4'hb
`define BCR_CC_GE 4'hc
`define BCR_CC_LT 4'hd
`define BCR_CC_GT 4'he
`define BCR_CC_LE 4'hf

// Second opcode byte fields of a register-direct bit instruction.
`define BCR_BITNO_MSB 6
`define BCR_BITNO_LSB 4
`define BCR_REGNO_MSB 3
`define BCR_REGNO_LSB 0

// Value returned by a byte read of a write-only location.
`define BCR_WO_READ 8'hff

// Sizes and reset values.
`define BCR_NREGS 16
`define BCR_STACK_DEPTH 8
`define BCR_PC_RESET 16'h0000
`define BCR_BYTE_RESET 8'h00

`endif

// ==== shared/bcr_pkg.sv ====
// Types shared by the branch-condition and bit read-modify-write block.
`default_nettype none

package bcr_pkg;

  // Instruction classes handed to the execution block.
  typedef enum logic [2:0] {
    BCR_K_BRANCH,
    BCR_K_CALL,
    BCR_K_RETURN,
    BCR_K_BIT_REG,
    BCR_K_BIT_MEM
  } bcr_kind_e;

  // Single-bit modify operations.
  typedef enum logic [2:0] {
    BCR_BIT_SET,
    BCR_BIT_CLEAR,
    BCR_BIT_INVERT,
    BCR_CARRY_STORE,
    BCR_INV_CARRY_STORE
  } bcr_bitop_e;

endpackage

`default_nettype wire

// ==== rtl/bcr_bit_modify.sv ====
// Single-bit modify of one byte, the middle step of a read-modify-write.
`timescale 1ns/1ps
`default_nettype none

module bcr_bit_modify
  import bcr_pkg::*;
(
  input wire logic [7:0] byte_in, // Byte as read
  input wire logic [2:0] bit_no_in, // Selected bit position 0 to 7
  input wire bcr_bitop_e op_in, // Modify operation
  input wire logic carry_in, // Carry flag for the store operations
  output logic [7:0] byte_out // Byte to write back
);

  always_comb begin
    byte_out = byte_in; // RQ4
    case (op_in)
      BCR_BIT_SET: byte_out[bit_no_in] = 1'b1;
      BCR_BIT_CLEAR: byte_out[bit_no_in] = 1'b0; // RQ4
      BCR_BIT_INVERT: byte_out[bit_no_in] = ~byte_in[bit_no_in];
      BCR_CARRY_STORE: byte_out[bit_no_in] = carry_in;
      BCR_INV_CARRY_STORE: byte_out[bit_no_in] = ~carry_in;
      default: byte_out = byte_in;
    endcase
  end

endmodule

`default_nettype wire

// ==== tb/bcr_mem_model.sv ====
// Memory and peripheral bus model that answers the read-modify-write cycles.
`timescale 1ns/1ps
`default_nettype none

module bcr_mem_model (
  input wire logic clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic req_in, // Bus request
  input wire logic we_in, // Write phase
  input wire logic [15:0] addr_in, // Address
  input wire logic [7:0] wdata_in, // Write data
  input wire logic slow_in, // Answer after three wait cycles
  output logic ack_out, // Cycle complete
  output logic [7:0] rdata_out, // Read data
  output logic wo_out, // Location is write-only
  output logic [7:0] last_wdata_out, // Last byte written
  output logic [15:0] last_waddr_out // Last address written
);
  logic [1:0] cnt_reg;
  logic [7:0] val;
  // The top half of the map is write-only.
  // Lines are inverted outside ack so stale data never matches.
  assign val = addr_in[7:0] ^ 8'h5a;
  assign rdata_out = ack_out ? val : ~val;
  assign wo_out = ack_out ? addr_in[15] : ~addr_in[15];
  always_ff @(negedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_out <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (req_in && !ack_out && cnt_reg == (slow_in ? 2'h3 : 2'h0)) begin
      ack_out <= 1'b1;
    end else begin
      ack_out <= 1'b0;
      cnt_reg <= (req_in && !ack_out) ? cnt_reg + 2'h1 : 2'h0;
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      last_wdata_out <= 8'h00;
      last_waddr_out <= 16'h0000;
    end else if (req_in && we_in && ack_out) begin
      last_wdata_out <= wdata_in;
      last_waddr_out <= addr_in;
    end
  end
endmodule

`default_nettype wire

// ==== tb/bcr_exec_props.sv ====
// Concurrent checks on the ports of the execution block.
`timescale 1ns/1ps
`default_nettype none

module bcr_exec_props
  import bcr_pkg::*;
(
  input wire logic core_clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic instr_valid_in, // Start
  input wire bcr_kind_e instr_kind_in, // Class
  input wire logic [3:0] condition_field_in, // Condition
  input wire bcr_bitop_e bit_op_in, // Bit operation
  input wire logic [7:0] op_byte_in, // Second byte
  input wire logic [15:0] addr_in, // Operand address
  input wire logic [7:0] disp_in, // Displacement
  input wire logic [15:0] cur_pc_in, // Current address
  input wire logic mem_ack_in, // Bus ack
  input wire logic [7:0] mem_rdata_in, // Read data
  input wire logic mem_wo_in, // Write-only
  input wire logic busy_out, // Busy
  input wire logic done_out, // Done
  input wire logic pc_valid_out, // New pc
  input wire logic [15:0] pc_out, // Next pc
  input wire logic branch_taken_out, // Branch result
  input wire logic mem_req_out, // Request
  input wire logic mem_we_out, // Write phase
  input wire logic [15:0] mem_addr_out, // Bus address
  input wire logic [7:0] mem_wdata_out // Write data
);
  logic take, rd_ack;
  logic [2:0] bit_reg;
  bcr_bitop_e op_reg;
  logic [7:0] rd_reg;
  assign take = instr_valid_in && !busy_out;
  assign rd_ack = mem_req_out && !mem_we_out && mem_ack_in;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bit_reg <= 3'h0;
      op_reg <= BCR_BIT_SET;
    end else if (take) begin
      bit_reg <= op_byte_in[6:4];
      op_reg <= bit_op_in;
    end
  end
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_reg <= 8'h00;
    end else if (rd_ack) begin
      rd_reg <= mem_wo_in ? 8'hff : mem_rdata_in;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  chk_fixed_cond: assert property (take && instr_kind_in == BCR_K_BRANCH &&
    condition_field_in[3:1] == 3'h0 |=> branch_taken_out == !$past(condition_field_in[0]))
    else $error("fixed condition gave wrong result");
  chk_branch_target: assert property (take && instr_kind_in == BCR_K_BRANCH |=>
    pc_valid_out &&
    pc_out == (branch_taken_out ? $past(cur_pc_in) + {{8{$past(disp_in[7])}}, $past(disp_in)}
    : $past(cur_pc_in))) else $error("branch target wrong");
  chk_call_target: assert property (take && instr_kind_in == BCR_K_CALL |=> pc_valid_out &&
    pc_out == $past(cur_pc_in) + {{8{$past(disp_in[7])}}, $past(disp_in)})
    else $error("call target wrong");
  chk_pc_done: assert property (pc_valid_out |-> done_out) else $error("pc without done");
  chk_read_start: assert property (take && instr_kind_in == BCR_K_BIT_MEM |=>
    mem_req_out && !mem_we_out && mem_addr_out == $past(addr_in)) else $error("no read first");
  chk_write_follow: assert property (rd_ack |=> mem_req_out && mem_we_out &&
    $stable(mem_addr_out)) else $error("no write after read");
  chk_addr_hold: assert property (mem_req_out && !$rose(mem_req_out) |->
    $stable(mem_addr_out)) else $error("address moved in cycle");
  chk_other_bits: assert property (rd_ack |=> ((mem_wdata_out ^ rd_reg) &
    ~(8'h01 << bit_reg)) == 8'h00) else $error("unselected bit changed");
  chk_clear_ones: assert property (rd_ack && op_reg == BCR_BIT_CLEAR |=>
    mem_wdata_out == (rd_reg & ~(8'h01 << bit_reg))) else $error("clear wrote wrong byte");
  chk_mem_done: assert property (mem_req_out && mem_we_out && mem_ack_in |=>
    !mem_req_out && done_out && !busy_out) else $error("write ack did not end op");
  cov_wo_read: cover property (rd_ack && mem_wo_in);
  cov_call: cover property (take && instr_kind_in == BCR_K_CALL);
  cov_taken: cover property (pc_valid_out && branch_taken_out);
endmodule

bind bcr_exec bcr_exec_props bcr_exec_props_inst (.*);

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking testbench of the execution block.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import bcr_pkg::*;
;
  localparam logic [14:0] BITS = {3'h4, 3'h1, 3'h0, 3'h7, 3'h6};
  logic core_clk_in, reset_in, instr_valid_in, flag_c_in, flag_z_in, flag_n_in, flag_v_in;
  bcr_kind_e instr_kind_in;
  bcr_bitop_e bit_op_in;
  logic [3:0] condition_field_in, reg_load_idx_in, reg_rd_idx_in;
  logic [7:0] op_byte_in, disp_in, mem_rdata_in, reg_load_data_in, mem_wdata_out, reg_rd_data_out;
  logic [15:0] addr_in, cur_pc_in, pc_out, mem_addr_out, last_waddr;
  logic mem_ack_in, mem_wo_in, reg_load_in, busy_out, done_out, pc_valid_out, slow_in;
  logic branch_taken_out, mem_req_out, mem_we_out;
  logic [7:0] last_wdata;
  int err_count = 0;
  int n_compared = 0;
  bcr_exec bcr_exec_inst (.*);
  bcr_mem_model bcr_mem_model_inst (.clk_in(core_clk_in), .reset_in(reset_in),
    .req_in(mem_req_out), .we_in(mem_we_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
    .slow_in(slow_in), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in), .wo_out(mem_wo_in),
    .last_wdata_out(last_wdata), .last_waddr_out(last_waddr));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic issue(input bcr_kind_e k);
    @(negedge core_clk_in);
    instr_kind_in = k;
    instr_valid_in = 1'b1;
    @(negedge core_clk_in);
    instr_valid_in = 1'b0;
  endtask
  function automatic logic cond(input logic [3:0] cc, input logic [3:0] f);
    logic c, z, n, v, e;
    {c, z, n, v} = f;
    case (cc[3:1])
      3'h0: e = 1'b0;
      3'h1: e = c | z;
      3'h2: e = c;
      3'h3: e = z;
      3'h4: e = v;
      3'h5: e = n;
      3'h6: e = n ^ v;
      default: e = z | (n ^ v);
    endcase
    return cc[0] ? e : !e;
  endfunction
  function automatic logic [7:0] modify(input logic [7:0] v, input logic [2:0] b, input int op,
                                        input logic c);
    logic [7:0] r;
    r = v;
    case (op)
      0: r[b] = 1'b1;
      1: r[b] = 1'b0;
      2: r[b] = !v[b];
      3: r[b] = c;
      default: r[b] = !c;
    endcase
    return r;
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_branch();
    logic t;
    for (int i = 0; i < 256; i++) begin
      condition_field_in = i[7:4];
      {flag_c_in, flag_z_in, flag_n_in, flag_v_in} = i[3:0];
      disp_in = 8'hf0;
      cur_pc_in = 16'h1000 + 16'(i);
      t = cond(i[7:4], i[3:0]);
      issue(BCR_K_BRANCH);
      check("branch_taken", {15'h0, branch_taken_out}, {15'h0, t});
      check("branch_pc", pc_out, t ? cur_pc_in - 16'h0010 : cur_pc_in);
    end
    $display("test branch finished");
  endtask
  task automatic t_call_ret();
    disp_in = 8'h10;
    cur_pc_in = 16'h2000;
    issue(BCR_K_CALL);
    check("call_pc", pc_out, 16'h2010);
    disp_in = 8'h80;
    cur_pc_in = 16'h3000;
    issue(BCR_K_CALL);
    check("call_pc", pc_out, 16'h2f80);
    issue(BCR_K_RETURN);
    check("return_pc", pc_out, 16'h3000);
    issue(BCR_K_RETURN);
    check("return_pc", pc_out, 16'h2000);
    $display("test call and return finished");
  endtask
  task automatic t_bit_reg();
    logic [2:0] b;
    for (int op = 0; op < 5; op++) begin
      b = BITS[op*3 +: 3];
      reg_load_idx_in = 4'(op + 9);
      reg_load_data_in = 8'ha5;
      reg_load_in = 1'b1;
      @(negedge core_clk_in);
      reg_load_in = 1'b0;
      flag_c_in = op[0];
      bit_op_in = bcr_bitop_e'(op);
      op_byte_in = {1'b0, b, reg_load_idx_in};
      reg_rd_idx_in = reg_load_idx_in;
      issue(BCR_K_BIT_REG);
      @(negedge core_clk_in);
      check("reg_byte", {8'h0, reg_rd_data_out},
            {8'h0, modify(8'ha5, b, op, op[0])});
    end
    $display("test register bits finished");
  endtask
  task automatic t_bit_mem();
    logic [7:0] rd;
    logic [2:0] b;
    int op;
    logic ok;
    for (int j = 0; j < 6; j++) begin
      op = (j == 5) ? 1 : j;
      // Offset from the register test so that together they reach all eight bit positions.
      b = (j == 5) ? 3'h0 : BITS[j*3 +: 3] + 3'h4;
      addr_in = (j == 5) ? 16'h80ff : 16'h0010 + 16'(j);
      rd = (j == 5) ? 8'hff : addr_in[7:0] ^ 8'h5a;
      slow_in = j[0];
      flag_c_in = j[0];
      bit_op_in = bcr_bitop_e'(op);
      op_byte_in = {1'b0, b, 4'h0};
      issue(BCR_K_BIT_MEM);
      ok = 1'b0;
      for (int k = 0; k < 40 && !ok; k++) begin
        @(negedge core_clk_in);
        ok = (done_out === 1'b1);
      end
      check("rmw_done", {15'h0, ok}, 16'h0001);
      check("rmw_addr", last_waddr, addr_in);
      check("rmw_byte", {8'h0, last_wdata}, {8'h0, modify(rd, b, op, j[0])});
    end
    $display("test memory bits finished");
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    #50000;
    err_count++;
    finish_test();
  end
  initial begin
    reset_in = 1'b1;
    instr_valid_in = 1'b0;
    instr_kind_in = BCR_K_BRANCH;
    bit_op_in = BCR_BIT_SET;
    {condition_field_in, op_byte_in, addr_in, disp_in, cur_pc_in} = '0;
    {flag_c_in, flag_z_in, flag_n_in, flag_v_in, reg_load_in, slow_in} = '0;
    {reg_load_idx_in, reg_load_data_in, reg_rd_idx_in} = '0;
    repeat (16) @(posedge core_clk_in);
    @(negedge core_clk_in);
    reset_in = 1'b0;
    t_branch();
    t_call_ret();
    t_bit_reg();
    t_bit_mem();
    finish_test();
  end
endmodule

`default_nettype wire
